//--- verilog/dss_sequencer.sv
/*
 dual slope converter sequencer: prescaler, phase machine, switch
 controls, polarity capture and result latch.
 holds all the logic of the block; the package gives the carrier
 types and the constants header names every count and code.
 assumes comparator and hold are synchronous to core_clk, that the
 analog switches settle well within one count clock, and that the
 zero crossing is only meaningful while the reference is applied.
 the display side reads result_ff whenever it likes; it only moves
 one core_clk after the cycle-end tick.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dss_consts.svh"
module dss_sequencer
    import dss_pkg::*;
#(
    parameter logic [5:0] PRESCALE = `DSS_PRESCALE
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmp_positive,   // comparator: integrator above zero
    input wire logic cmp_zero_cross, // comparator: zero crossing seen
    input wire logic hold_n,         // low freezes the result latch
    output var dss_sw_s sw_ff,       // analog switch controls
    output var dss_result_s result_ff, // display latch
    output logic count_tick_ff,      // one pulse per count clock
    output logic conv_done_ff        // pulse at cycle end
);
    // state of the sequencer: one phase register, two counters that
    // run on count clock ticks, and what the current cycle learnt.
    // the whole-cycle counter alone decides when auto-zero ends, so
    // an early zero crossing stretches auto-zero and the cycle length
    // never depends on the input magnitude.
    // the phase counter restarts at every phase change; in the
    // reference phase its value at the crossing is the reading.
    dss_phase_e phase_ff, nxt_phase;   // current phase, one-hot
    logic [5:0] pre_ff, nxt_pre;       // oscillator prescaler
    logic [6:0] cyc_ff, nxt_cyc;       // counts in whole cycle
    logic [6:0] ph_ff, nxt_ph;         // counts in current phase
    logic [6:0] ri_ff, nxt_ri;         // reference count held
    logic pol_ff, nxt_pol;             // captured sign, 1 = negative
    logic ovr_ff, nxt_ovr;
    logic ri_done_ff, nxt_ri_done;     // crossing seen this cycle
    dss_sw_s nxt_sw;
    dss_result_s nxt_result;
    logic nxt_tick, nxt_done;
    logic tick;

    // prescaler and phase machine next state.
    // the prescaler wraps every PRESCALE core_clk edges and the wrap
    // is the count clock tick; nothing else in here moves between
    // ticks, so every phase length is a whole number of counts.
    // the tick is also sent out registered so the far side can pace
    // its integration on exactly the same counts.
    // cycle end is the last auto-zero count: the result of the cycle
    // that just finished goes to the latch there, and signal
    // integration of the next cycle starts on the same tick.
    // a cheaper design could drop the phase counter and derive it
    // from the cycle counter, but the reading would then need an
    // offset subtraction on the critical compare.
    always_comb begin
        nxt_pre = pre_ff + 6'h01;
        tick = 1'b0;
        if (pre_ff == PRESCALE - 6'h01) begin
            nxt_pre = 6'h00;
            tick = 1'b1;
        end
        nxt_phase = phase_ff;
        nxt_cyc = cyc_ff;
        nxt_ph = ph_ff;
        nxt_ri = ri_ff;
        nxt_pol = pol_ff;
        nxt_ovr = ovr_ff;
        nxt_ri_done = ri_done_ff;
        nxt_result = result_ff;
        nxt_done = 1'b0;
        nxt_tick = tick;
        if (tick) begin
            nxt_cyc = cyc_ff + 7'h01;
            nxt_ph = ph_ff + 7'h01;
            case (phase_ff)
                DSS_AZ: begin
                    // end of cycle: 80 counts total, phases restart
                    if (cyc_ff == `DSS_CYCLE_LEN - 7'h01) begin
                        nxt_phase = DSS_SI;
                        nxt_cyc = 7'h00;
                        nxt_ph = 7'h00;
                        nxt_ri_done = 1'b0;
                    end
                end
                DSS_SI: begin
                    if (ph_ff == `DSS_SI_LEN - 7'h01) begin
                        // comparator sign alone, no magnitude gate
                        nxt_pol = ~cmp_positive;
                        nxt_phase = DSS_RI;
                        nxt_ph = 7'h00;
                    end
                end
                DSS_RI: begin
                    // crossing comparator only looked at on ticks in this
                    // phase; outside it the crossing line is ignored.
                    // a crossing seen on count k gives reading k, so
                    // the reading spans 0..40 inside a 41 count window.
                    // the window running out means the input exceeded
                    // full scale; the reading is pinned at the top.
                    if (cmp_zero_cross && !ri_done_ff) begin
                        nxt_ri = ph_ff;
                        nxt_ovr = 1'b0;
                        nxt_ri_done = 1'b1;
                        nxt_phase = DSS_AZ;
                        nxt_ph = 7'h00;
                    end else if (ph_ff == `DSS_RI_WIN - 7'h01) begin
                        nxt_ri = `DSS_RI_MAXCNT;
                        nxt_ovr = 1'b1;
                        nxt_phase = DSS_AZ;
                        nxt_ph = 7'h00;
                    end
                end
                default: begin
                    nxt_phase = DSS_AZ;
                    nxt_ph = 7'h00;
                end
            endcase
            if (phase_ff == DSS_AZ &&
                cyc_ff == `DSS_CYCLE_LEN - 7'h01) begin
                nxt_done = 1'b1;
                if (hold_n) begin
                    nxt_result.value = ri_ff;
                    nxt_result.negative = pol_ff;
                    nxt_result.over_range = ovr_ff;
                end
            end
        end
    end

    // switch controls decoded from next phase so they track it.
    // decoding from the next state keeps the switch flops in step
    // with the phase flop, with no extra cycle of skew between the
    // phase change and the analog gates moving.
    // the reference polarity follows the sign just captured, so it
    // always drives the integrator back toward zero.
    // unknown phase codes fall back to inputs open: the safe state.
    always_comb begin
        nxt_sw = '0;
        case (nxt_phase)
            DSS_AZ: begin
                nxt_sw.inputs_open = 1'b1;
                nxt_sw.short_to_common = 1'b1;
                nxt_sw.az_loop_closed = 1'b1;
            end
            DSS_SI: begin
                nxt_sw.connect_inputs = 1'b1;
            end
            DSS_RI: begin
                nxt_sw.neg_to_common = 1'b1;
                nxt_sw.ref_positive = nxt_pol;
                nxt_sw.ref_negative = ~nxt_pol;
            end
            default: begin
                nxt_sw.inputs_open = 1'b1;
            end
        endcase
    end

    // registers; reset starts in auto-zero with prescaler and phase counter cleared.
    // the cycle counter is preset so the first auto-zero lasts the
    // minimum length; the first latched result is a zero reading.
    // switches come out of reset already in the auto-zero pattern,
    // so the integrator is shorted from the first edge on.
    // reset is synchronous: it needs one core_clk edge to take hold.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_ff <= DSS_AZ;
            pre_ff <= 6'h00;
            cyc_ff <= `DSS_CYCLE_LEN - `DSS_AZ_FIRST;
            ph_ff <= 7'h00;
            ri_ff <= 7'h00;
            pol_ff <= 1'b0;
            ovr_ff <= 1'b0;
            ri_done_ff <= 1'b0;
            sw_ff <= dss_sw_s'(`DSS_SW_AZ_CODE);
            result_ff <= '0;
            count_tick_ff <= 1'b0;
            conv_done_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            pre_ff <= nxt_pre;
            cyc_ff <= nxt_cyc;
            ph_ff <= nxt_ph;
            ri_ff <= nxt_ri;
            pol_ff <= nxt_pol;
            ovr_ff <= nxt_ovr;
            ri_done_ff <= nxt_ri_done;
            sw_ff <= nxt_sw;
            result_ff <= nxt_result;
            count_tick_ff <= nxt_tick;
            conv_done_ff <= nxt_done;
        end
    end
endmodule
`default_nettype wire

//--- verilog/dss_consts.svh
/*
 constants for the dual slope conversion sequencer.
 assumes inclusion by bare name from verilog/.
*/
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH
`define DSS_PRESCALE 6'h20
`define DSS_CYCLE_LEN 7'h50
`define DSS_SI_LEN 7'h14
`define DSS_AZ_MIN 7'h13
`define DSS_AZ_MAX 7'h3b
`define DSS_RI_WIN 7'h29
`define DSS_RI_MAXCNT 7'h28
`define DSS_AZ_FIRST 7'h13
`define DSS_SW_AZ_CODE 7'h70
`endif

//--- verilog/dss_pkg.sv
/*
 types for the dual slope conversion sequencer.
 assumes nothing of its surroundings.
*/
package dss_pkg;
    // sequencer phases, one-hot
    typedef enum logic [2:0] {
        DSS_AZ = 3'b001,
        DSS_SI = 3'b010,
        DSS_RI = 3'b100
    } dss_phase_e;
    // analog switch controls
    typedef struct packed {
        logic inputs_open;
        logic short_to_common;
        logic az_loop_closed;
        logic connect_inputs;
        logic neg_to_common;
        logic ref_positive;
        logic ref_negative;
    } dss_sw_s;
    // display latch contents
    typedef struct packed {
        logic [6:0] value;
        logic negative;
        logic over_range;
    } dss_result_s;
endpackage

//--- testbench/dss_chk.sv
/* port checker for dss_sequencer.
 assumes it is bound into each dss_sequencer. */
`timescale 1ns/1ps
`default_nettype none
module dss_chk
    import dss_pkg::*;
#(parameter logic [5:0] PRESCALE = 6'h20) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmp_positive,
    input wire logic hold_n,
    input wire dss_sw_s sw_ff,
    input wire dss_result_s result_ff,
    input wire logic count_tick_ff,
    input wire logic conv_done_ff
);
    int gap_ff, cyc_ff, ph_ff; // gap_ff and cyc_ff negative until a whole span is seen, ph_ff starts at 1
    always_ff @(posedge core_clk) begin
        gap_ff <= !rst_n ? -999 : count_tick_ff ? 0 : gap_ff + 1;
        cyc_ff <= !rst_n ? -9999 : conv_done_ff ? 0 : cyc_ff + 1;
        // a phase starts on a tick, so the change edge counts as one
        ph_ff <= !rst_n ? 1 : $changed(sw_ff) ? int'(count_tick_ff) :
            ph_ff + int'(count_tick_ff);
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_si_end; $fell(sw_ff.connect_inputs); endsequence
    a_tick_gap: assert property (count_tick_ff && gap_ff >= 0 |->
        gap_ff == PRESCALE - 1) else $error("tick gap");
    a_cycle_len: assert property (conv_done_ff && cyc_ff >= 0 |->
        cyc_ff == 80 * PRESCALE - 1) else $error("cycle length");
    a_si_len: assert property (s_si_end |-> ph_ff == 20)
        else $error("signal length");
    a_az_len: assert property ($fell(sw_ff.az_loop_closed) |->
        sw_ff.connect_inputs && ph_ff inside {[19:59]}) else $error("az");
    a_az_switches: assert property (sw_ff.az_loop_closed |->
        sw_ff.inputs_open && sw_ff.short_to_common) else $error("az switch");
    a_ref_sign: assert property (s_si_end |-> sw_ff.neg_to_common &&
        sw_ff.ref_positive == !$past(cmp_positive)) else $error("ref sign");
    a_hold_keeps: assert property (
        !conv_done_ff || !$past(hold_n) |-> $stable(result_ff))
        else $error("result load");
    a_over_value: assert property (result_ff.over_range |->
        result_ff.value == 7'h28) else $error("over range");
endmodule
bind dss_sequencer dss_chk #(.PRESCALE(PRESCALE)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .cmp_positive(cmp_positive),
    .hold_n(hold_n), .sw_ff(sw_ff), .result_ff(result_ff),
    .count_tick_ff(count_tick_ff), .conv_done_ff(conv_done_ff));
`default_nettype wire

//--- testbench/dss_analog.sv
/* integrator and comparator model behind the switch controls.
 assumes vin in counts, so a good reading equals its magnitude. */
`timescale 1ns/1ps
`default_nettype none
module dss_analog
    import dss_pkg::*;
(
    input wire logic core_clk,
    input wire logic count_tick_ff,
    input wire dss_sw_s sw_ff,
    input wire logic signed [7:0] vin,
    output logic cmp_positive,
    output logic cmp_zero_cross
);
    int q = 0; // integrator charge, reference removes 20 per count
    dss_sw_s per_sw = '0; // switches of the count just ended
    // charge of a count is booked once that count is over
    always @(posedge core_clk)
        if (count_tick_ff) begin
            per_sw <= sw_ff;
            if (per_sw.short_to_common) q <= 0;
            else if (per_sw.connect_inputs) q <= q + vin;
            else if (per_sw.ref_positive) q <= q + 20;
            else if (per_sw.ref_negative) q <= q - 20;
        end
    assign cmp_positive = q >= 0;
    // not masked outside the reference phase, like a real comparator
    assign cmp_zero_cross = sw_ff.ref_positive ? q >= 0 : q <= 0;
endmodule
`default_nettype wire

//--- testbench/dss_sequencer_tb.sv
/* self-checking bench for dss_sequencer with the analog model.
 assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer_tb
    import dss_pkg::*;
;
    logic core_clk = 0, rst_n = 0, hold_n = 1;
    logic cmp_positive, cmp_zero_cross, count_tick_ff, conv_done_ff;
    logic signed [7:0] vin = 0, v;
    logic [31:0] lfsr = 32'h0000_071f;
    dss_sw_s sw_ff;
    dss_result_s result_ff;
    int fail_count = 0, checked = 0;
    logic signed [7:0] corner [7] = '{0, -1, 1, 40, -40, 41, -45};
    dss_sequencer #(.PRESCALE(6'h04)) dut ( // short count clock
        .core_clk(core_clk), .rst_n(rst_n), .cmp_positive(cmp_positive),
        .cmp_zero_cross(cmp_zero_cross), .hold_n(hold_n), .sw_ff(sw_ff),
        .result_ff(result_ff), .count_tick_ff(count_tick_ff),
        .conv_done_ff(conv_done_ff));
    dss_analog model (.core_clk(core_clk), .count_tick_ff(count_tick_ff),
        .sw_ff(sw_ff), .vin(vin), .cmp_positive(cmp_positive),
        .cmp_zero_cross(cmp_zero_cross));
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial forever #20 core_clk = ~core_clk;
    function automatic dss_result_s want(logic signed [7:0] x);
        int m = x < 0 ? -x : x;
        return '{m > 40 ? 7'h28 : 7'(m), x < 0, m > 40};
    endfunction
    task automatic convert(logic signed [7:0] x, logic h, dss_result_s w);
        int n;
        vin = x;
        hold_n = h;
        repeat (2) begin
            #40;
            for (n = 0; n < 400 && conv_done_ff !== 1'b1; n++) #40;
            if (n == 400) begin
                fail_count++;
                $display("MISMATCH %0t %h %h", $time, conv_done_ff, 1'b1);
            end
        end
        checked++;
        if (result_ff !== w) begin
            fail_count++;
            $display("MISMATCH %0t %h %h", $time, result_ff, w);
        end
        $display("done %0d", x);
    endtask
    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1;
        foreach (corner[i]) convert(corner[i], 1, want(corner[i]));
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            v = 8'(lfsr % 91) - 8'sd45;
            convert(v, 1, want(v));
        end
        convert(8'sd9, 0, want(v));
        convert(8'sd9, 1, want(8'sd9));
        test_done();
    end
endmodule
`default_nettype wire
